// file: hdl/ls_light_sensor_regs.sv
`timescale 1ns/1ps
`include "ls_defines.svh"
module ls_light_sensor_regs
   import ls_pkg::*;
#(
   parameter int CYC_PER_MS = `LS_CYC_PER_MS,
   parameter int TIMEOUT_CYC = `LS_TIMEOUT_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic linkClk,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic intIn,
   output logic intOut,
   output logic intOe,
   input wire logic [15:0] lightRaw,
   input wire logic [15:0] bbandRaw,
   output logic afeActive,
   output logic afeSensLow,
   output logic afeGainDouble,
   output logic afeBbandEn,
   output logic measStrobe
);
   // ----------------------------------------------------------------------
   // core-domain state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic togMeta;       // config toggle, first stage
      logic togSync;       // config toggle, second stage
      logic togPrev;       // for change detection
      logic [15:0] cfg;    // local copy of light_config
      logic [15:0] upTh;   // local copy of upper threshold
      logic [15:0] loTh;   // local copy of lower threshold
      logic [2:0] psave;   // local copy of power-save bits
      logic [31:0] timer;  // cycles into current measurement
      logic [3:0] persCnt; // consecutive out-of-window readings
      ls_result_t res;     // last result, stable between toggles
      logic resTog;        // flips once per finished measurement
      logic strobe;        // one-cycle measurement pulse
   } ls_core_t;

   // ----------------------------------------------------------------------
   // link-domain state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic sclMeta, sclSync, sclPrev;
      logic sdaMeta, sdaSync, sdaPrev;
      logic resMeta, resSync, resPrev;
      ls_state_t st;
      logic [3:0] bitCnt;
      logic [7:0] shift;
      logic [1:0] byteIdx;
      logic isRead;
      logic txHi;          // next read byte is the high byte
      logic nack;
      logic [7:0] cmd;
      logic [7:0] loByte;
      logic drive;         // sda pulled low
      logic [31:0] toCnt;
      logic [15:0] cfg, upTh, loTh, psave, light, bband;
      logic flagLow, flagHigh;
      logic cfgTog;
   } ls_link_t;

   ls_core_t cc, nxt_cc;
   ls_link_t lk, nxt_lk;
   logic rstMeta_ff, rstSync_ff;  // core reset carried into link domain
   logic linkRstN;

   // ----------------------------------------------------------------------
   // reset synchroniser for the link domain
   // ----------------------------------------------------------------------
   always_ff @(posedge linkClk) begin
      rstMeta_ff <= reset_n;
      rstSync_ff <= rstMeta_ff;
   end
   assign linkRstN = rstSync_ff;

   // ----------------------------------------------------------------------
   // core: measurement timing, doubling and persistence
   // ----------------------------------------------------------------------
   always_comb begin
      logic [31:0] period;
      logic [15:0] light, bband, cmpVal;
      logic [3:0] persNeed, persNext;
      logic above, below;
      period = 32'h0;
      light = 16'h0;
      bband = 16'h0;
      cmpVal = 16'h0;
      persNeed = 4'h0;
      persNext = 4'h0;
      above = 1'b0;
      below = 1'b0;
      nxt_cc = cc;
      nxt_cc.strobe = 1'b0;
      nxt_cc.togMeta = lk.cfgTog;
      nxt_cc.togSync = cc.togMeta;
      nxt_cc.togPrev = cc.togSync;
      // link registers are quiet for many bit times after a toggle
      if (cc.togSync != cc.togPrev) begin
         nxt_cc.cfg = lk.cfg;
         nxt_cc.upTh = lk.upTh;
         nxt_cc.loTh = lk.loTh;
         nxt_cc.psave = lk.psave[2:0];
      end
      period = 32'(ls_it_ms(cc.cfg[`LS_CFG_IT_HI:`LS_CFG_IT_LO]) * CYC_PER_MS);
      if (cc.psave[`LS_PS_ENABLE]) begin
         period = period
            + 32'(ls_wait_ms(cc.psave[`LS_PS_WAIT_HI:`LS_PS_WAIT_LO]) * CYC_PER_MS);
      end
      if (cc.cfg[`LS_CFG_SHUTDOWN]) begin
         // no measurements; result held on link side
         nxt_cc.timer = 32'h0;
      end else if (cc.timer + 32'h1 >= period) begin
         nxt_cc.timer = 32'h0;
         nxt_cc.strobe = 1'b1;
         light = ls_double(lightRaw, cc.cfg[`LS_CFG_DOUBLE]);
         bband = cc.cfg[`LS_CFG_BBAND_EN] ? ls_double(bbandRaw, cc.cfg[`LS_CFG_DOUBLE])
                                          : cc.res.bband;
         cmpVal = cc.cfg[`LS_CFG_INT_CH] ? bband : light;
         above = cmpVal > cc.upTh;
         below = cmpVal < cc.loTh;
         persNeed = 4'h1 << cc.cfg[`LS_CFG_PERS_HI:`LS_CFG_PERS_LO];
         persNext = cc.persCnt + 4'h1;
         nxt_cc.res.evLow = 1'b0;
         nxt_cc.res.evHigh = 1'b0;
         if (!(above || below)) begin
            nxt_cc.persCnt = 4'h0;
         end else if (persNext >= persNeed) begin
            nxt_cc.persCnt = 4'h0;
            // events only while interrupts are enabled
            nxt_cc.res.evHigh = above & cc.cfg[`LS_CFG_INT_EN];
            nxt_cc.res.evLow = below & cc.cfg[`LS_CFG_INT_EN];
         end else begin
            nxt_cc.persCnt = persNext;
         end
         nxt_cc.res.light = light;
         nxt_cc.res.bband = bband;
         nxt_cc.resTog = ~cc.resTog;
      end else begin
         nxt_cc.timer = cc.timer + 32'h1;
      end
   end

   // core register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cc <= '0;
         cc.cfg <= `LS_CONFIG_RESET;
         cc.upTh <= `LS_UPPER_RESET;
         cc.loTh <= `LS_THRESH_RESET;
      end else begin
         cc <= nxt_cc;
      end
   end

   // ----------------------------------------------------------------------
   // link: two-wire target, register file, flags
   // ----------------------------------------------------------------------
   always_comb begin
      logic start, stop, rise, fall, setLow, setHigh, clrFlags;
      logic [15:0] rdWord;
      logic [7:0] txByte;
      start = 1'b0;
      stop = 1'b0;
      rise = 1'b0;
      fall = 1'b0;
      setLow = 1'b0;
      setHigh = 1'b0;
      clrFlags = 1'b0;
      rdWord = 16'h0;
      txByte = 8'h0;
      nxt_lk = lk;
      nxt_lk.sclMeta = sclIn;
      nxt_lk.sclSync = lk.sclMeta;
      nxt_lk.sclPrev = lk.sclSync;
      nxt_lk.sdaMeta = sdaIn;
      nxt_lk.sdaSync = lk.sdaMeta;
      nxt_lk.sdaPrev = lk.sdaSync;
      nxt_lk.resMeta = cc.resTog;
      nxt_lk.resSync = lk.resMeta;
      nxt_lk.resPrev = lk.resSync;
      start = lk.sclSync & lk.sclPrev & lk.sdaPrev & ~lk.sdaSync;
      stop = lk.sclSync & lk.sclPrev & ~lk.sdaPrev & lk.sdaSync;
      rise = lk.sclSync & ~lk.sclPrev;
      fall = ~lk.sclSync & lk.sclPrev;
      // word selected by the command code; reserved bits read zero
      unique case (lk.cmd)
         `LS_CMD_CONFIG: rdWord = lk.cfg;
         `LS_CMD_UPPER: rdWord = lk.upTh;
         `LS_CMD_LOWER: rdWord = lk.loTh;
         `LS_CMD_PSAVE: rdWord = lk.psave;
         `LS_CMD_LIGHT: rdWord = lk.light;
         `LS_CMD_BBAND: rdWord = lk.bband;
         `LS_CMD_FLAGS: rdWord = {lk.flagLow, lk.flagHigh, 14'h0};
         default: rdWord = 16'h0;
      endcase
      txByte = lk.txHi ? rdWord[15:8] : rdWord[7:0];
      // new result from the core domain
      if (lk.resSync != lk.resPrev) begin
         nxt_lk.light = cc.res.light;
         nxt_lk.bband = cc.res.bband;
         setLow = cc.res.evLow;
         setHigh = cc.res.evHigh;
      end
      // stuck-low bus watchdog
      if (!lk.sclSync || !lk.sdaSync) begin
         nxt_lk.toCnt = (lk.toCnt >= 32'(TIMEOUT_CYC)) ? lk.toCnt : lk.toCnt + 32'h1;
      end else begin
         nxt_lk.toCnt = 32'h0;
      end
      if (lk.toCnt == 32'(TIMEOUT_CYC - 1)) begin
         nxt_lk.st = LS_IDLE;
         nxt_lk.drive = 1'b0;
      end else if (stop) begin
         nxt_lk.st = LS_IDLE;
         nxt_lk.drive = 1'b0;
      end else if (start) begin
         // start or repeated start: expect the address byte
         nxt_lk.st = LS_RX;
         nxt_lk.bitCnt = 4'h0;
         nxt_lk.byteIdx = 2'h0;
         nxt_lk.drive = 1'b0;
      end else begin
         unique case (lk.st)
            LS_IDLE: begin
               nxt_lk.drive = 1'b0;
            end
            LS_RX: begin
               if (rise) begin
                  nxt_lk.shift = {lk.shift[6:0], lk.sdaSync};
                  nxt_lk.bitCnt = lk.bitCnt + 4'h1;
               end else if (fall && lk.bitCnt == 4'h8) begin
                  nxt_lk.bitCnt = 4'h0;
                  nxt_lk.st = LS_ACK;
                  nxt_lk.drive = 1'b1;
                  unique case (lk.byteIdx)
                     2'h0: begin
                        if (lk.shift[7:1] != `LS_TARGET_ADDR) begin
                           nxt_lk.st = LS_IDLE;
                           nxt_lk.drive = 1'b0;
                        end
                        nxt_lk.isRead = lk.shift[0];
                        nxt_lk.txHi = 1'b0;
                     end
                     2'h1: nxt_lk.cmd = lk.shift;
                     2'h2: nxt_lk.loByte = lk.shift;
                     default: begin
                        // word complete; read-only codes ignore writes
                        unique case (lk.cmd)
                           `LS_CMD_CONFIG: begin
                              nxt_lk.cfg = {lk.shift, lk.loByte} & `LS_CONFIG_MASK;
                              nxt_lk.cfgTog = ~lk.cfgTog;
                           end
                           `LS_CMD_UPPER: begin
                              nxt_lk.upTh = {lk.shift, lk.loByte};
                              nxt_lk.cfgTog = ~lk.cfgTog;
                           end
                           `LS_CMD_LOWER: begin
                              nxt_lk.loTh = {lk.shift, lk.loByte};
                              nxt_lk.cfgTog = ~lk.cfgTog;
                           end
                           `LS_CMD_PSAVE: begin
                              nxt_lk.psave = {lk.shift, lk.loByte} & `LS_PSAVE_MASK;
                              nxt_lk.cfgTog = ~lk.cfgTog;
                           end
                           default: ;
                        endcase
                     end
                  endcase
               end
            end
            LS_ACK: begin
               if (fall) begin
                  if (lk.isRead) begin
                     // first data bit goes out as the ack is released
                     nxt_lk.st = LS_TX;
                     nxt_lk.shift = txByte;
                     nxt_lk.drive = ~txByte[7];
                  end else begin
                     nxt_lk.st = LS_RX;
                     nxt_lk.drive = 1'b0;
                     // extra bytes past a word start a new word
                     nxt_lk.byteIdx = (lk.byteIdx == 2'h3) ? 2'h2 : lk.byteIdx + 2'h1;
                  end
               end
            end
            LS_TX: begin
               if (fall) begin
                  nxt_lk.bitCnt = lk.bitCnt + 4'h1;
                  if (lk.bitCnt == 4'h7) begin
                     nxt_lk.st = LS_MACK;
                     nxt_lk.drive = 1'b0;
                     nxt_lk.txHi = ~lk.txHi;
                  end else begin
                     nxt_lk.shift = {lk.shift[6:0], 1'b0};
                     nxt_lk.drive = ~lk.shift[6];
                  end
               end
            end
            LS_MACK: begin
               if (rise) begin
                  nxt_lk.nack = lk.sdaSync;
               end else if (fall) begin
                  nxt_lk.bitCnt = 4'h0;
                  if (lk.nack) begin
                     nxt_lk.st = LS_IDLE;
                  end else begin
                     // controller wants more: alternate low and high bytes
                     nxt_lk.st = LS_TX;
                     nxt_lk.shift = txByte;
                     nxt_lk.drive = ~txByte[7];
                     // flags sit in the high byte, so clear only once it is loaded
                     clrFlags = (lk.cmd == `LS_CMD_FLAGS) && lk.txHi;
                  end
               end
            end
         endcase
      end
      // a crossing arriving with the clearing read survives it
      nxt_lk.flagLow = (lk.flagLow & ~clrFlags) | setLow;
      nxt_lk.flagHigh = (lk.flagHigh & ~clrFlags) | setHigh;
   end

   // link register
   always_ff @(posedge linkClk) begin
      if (!linkRstN) begin
         lk <= '0;
         lk.st <= LS_IDLE;
         lk.sclMeta <= 1'b1;
         lk.sclSync <= 1'b1;
         lk.sclPrev <= 1'b1;
         lk.sdaMeta <= 1'b1;
         lk.sdaSync <= 1'b1;
         lk.sdaPrev <= 1'b1;
         lk.cfg <= `LS_CONFIG_RESET;
         lk.upTh <= `LS_UPPER_RESET;
         lk.loTh <= `LS_THRESH_RESET;
         lk.psave <= `LS_PSAVE_RESET;
      end else begin
         lk <= nxt_lk;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign sdaOut = 1'b0;
   assign sdaOe = lk.drive;
   assign intOut = 1'b0;
   assign intOe = (lk.flagLow | lk.flagHigh) & lk.cfg[`LS_CFG_INT_EN];
   assign afeActive = ~cc.cfg[`LS_CFG_SHUTDOWN];
   assign afeSensLow = cc.cfg[`LS_CFG_SENSITIVITY_SELECT];
   assign afeGainDouble = cc.cfg[`LS_CFG_GAIN];
   assign afeBbandEn = cc.cfg[`LS_CFG_BBAND_EN];
   assign measStrobe = cc.strobe;
endmodule // ls_light_sensor_regs

// file: hdl/ls_defines.svh
`ifndef LS_DEFINES_SVH
`define LS_DEFINES_SVH
// ----------------------------------------------------------------------
// bus addressing
// ----------------------------------------------------------------------
`define LS_TARGET_ADDR 7'h29
`define LS_CMD_CONFIG 8'h00
`define LS_CMD_UPPER 8'h01
`define LS_CMD_LOWER 8'h02
`define LS_CMD_PSAVE 8'h03
`define LS_CMD_LIGHT 8'h04
`define LS_CMD_BBAND 8'h05
`define LS_CMD_FLAGS 8'h06
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define LS_CFG_SHUTDOWN 0
`define LS_CFG_INT_EN 1
`define LS_CFG_BBAND_EN 2
`define LS_CFG_INT_CH 3
`define LS_CFG_PERS_LO 4
`define LS_CFG_PERS_HI 5
`define LS_CFG_IT_LO 6
`define LS_CFG_IT_HI 9
`define LS_CFG_GAIN 10
`define LS_CFG_DOUBLE 11
`define LS_CFG_SENSITIVITY_SELECT 12
`define LS_PS_ENABLE 0
`define LS_PS_WAIT_LO 1
`define LS_PS_WAIT_HI 2
`define LS_FLAG_LOW 15
`define LS_FLAG_HIGH 14
// ----------------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------------
`define LS_CONFIG_RESET 16'h0000
`define LS_THRESH_RESET 16'h0000
`define LS_UPPER_RESET 16'hFFFF
`define LS_PSAVE_RESET 16'h0000
`define LS_CONFIG_MASK 16'h1FFF
`define LS_PSAVE_MASK 16'h0007
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define LS_CLK_PERIOD_NS 100
`define LS_LINK_PERIOD_NS 160
`define LS_NS_PER_MS 1000000
`define LS_TIMEOUT_MIN_MS 25
`define LS_TIMEOUT_MAX_MS 35
`define LS_CYC_PER_MS (`LS_NS_PER_MS / `LS_CLK_PERIOD_NS)
`define LS_TIMEOUT_CYC ((`LS_TIMEOUT_MIN_MS * `LS_NS_PER_MS + `LS_LINK_PERIOD_NS - 1) / `LS_LINK_PERIOD_NS)
`endif

// file: hdl/ls_pkg.sv
package ls_pkg;
   // ----------------------------------------------------------------------
   // link-side transfer states
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {LS_IDLE, LS_RX, LS_ACK, LS_TX, LS_MACK} ls_state_t;

   // one finished measurement handed from core to link side
   typedef struct packed {
      logic [15:0] light;
      logic [15:0] bband;
      logic evLow;
      logic evHigh;
   } ls_result_t;

   // integration period in ms from its 4-bit code; unlisted codes act as 100 ms
   function automatic int ls_it_ms(input logic [3:0] code);
      case (code)
         4'hC: return 25;
         4'h8: return 50;
         4'h1: return 200;
         4'h2: return 400;
         4'h3: return 800;
         default: return 100;
      endcase
   endfunction

   // power-save wait in ms from its 2-bit code
   function automatic int ls_wait_ms(input logic [1:0] code);
      return 400 << code;
   endfunction

   // digital doubling, saturating at full scale
   function automatic logic [15:0] ls_double(input logic [15:0] x, input logic en);
      if (!en) return x;
      return x[15] ? 16'hFFFF : {x[14:0], 1'b0};
   endfunction
endpackage

// file: verification/ls_checker.sv
`timescale 1ns/1ps
module ls_checker
   import ls_pkg::*;
#(
   parameter int TIMEOUT_CYC = 200
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic linkClk,
   input wire logic sclIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic intOut,
   input wire logic intOe,
   input wire logic afeActive,
   input wire logic measStrobe
);
   // -----------------------------
   // helper counters
   // -----------------------------
   logic [11:0] sinceMeas_ff; // clk cycles since last strobe, saturating
   logic [9:0] sinceFall_ff; // link cycles since scl fell
   logic [9:0] lowHold_ff; // link cycles of data pull while scl low
   logic sclPrev_ff; // scl one link cycle ago

   // measurement spacing in the core domain
   always_ff @(posedge clk) begin
      if (!reset_n) sinceMeas_ff <= 12'h000;
      else if (measStrobe) sinceMeas_ff <= 12'h001;
      else if (sinceMeas_ff != 12'hFFF) sinceMeas_ff <= sinceMeas_ff + 12'h001;
   end

   // bus timing in the link domain; saturating so idle never wraps
   always_ff @(posedge linkClk) begin
      sclPrev_ff <= sclIn;
      if (!reset_n || (sclPrev_ff && !sclIn)) sinceFall_ff <= 10'h000;
      else if (sinceFall_ff != 10'h3FF) sinceFall_ff <= sinceFall_ff + 10'h001;
      if (!reset_n || sclIn || !sdaOe) lowHold_ff <= 10'h000;
      else if (lowHold_ff != 10'h3FF) lowHold_ff <= lowHold_ff + 10'h001;
   end

   // -----------------------------
   // properties
   // -----------------------------
   a_pins_low: assert property (@(posedge clk) disable iff (!reset_n)
      sdaOut == 1'b0 && intOut == 1'b0)
      else $error("open-drain pin driven high");
   a_meas_awake: assert property (@(posedge clk) disable iff (!reset_n)
      measStrobe |-> afeActive)
      else $error("measurement during shutdown");
   a_meas_spacing: assert property (@(posedge clk) disable iff (!reset_n)
      measStrobe |-> sinceMeas_ff >= 12'd249)
      else $error("measurements closer than shortest period");
   a_int_after_meas: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(intOe) |-> sinceMeas_ff <= 12'd30)
      else $error("interrupt raised without a measurement");
   a_ack_timeout: assert property (@(posedge linkClk) disable iff (!reset_n)
      lowHold_ff <= 10'(TIMEOUT_CYC + 8))
      else $error("data pull kept past bus timeout");
   a_drive_after_fall: assert property (@(posedge linkClk) disable iff (!reset_n)
      $rose(sdaOe) |-> sinceFall_ff <= 10'd8)
      else $error("data pull started away from a clock fall");
   a_stable_scl_high: assert property (@(posedge linkClk) disable iff (!reset_n)
      sclIn && sclPrev_ff && sinceFall_ff >= 10'd8 |-> $stable(sdaOe))
      else $error("data changed while clock high");
   a_int_drop_bus: assert property (@(posedge linkClk) disable iff (!reset_n)
      $fell(intOe) |-> sinceFall_ff <= 10'd16)
      else $error("interrupt released without a bus access");
endmodule // ls_checker

bind ls_light_sensor_regs ls_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) ls_checker_inst (
   .clk(clk), .reset_n(reset_n), .linkClk(linkClk), .sclIn(sclIn), .sdaOut(sdaOut),
   .sdaOe(sdaOe), .intOut(intOut), .intOe(intOe), .afeActive(afeActive),
   .measStrobe(measStrobe));

// file: verification/ls_host_model.sv
`timescale 1ns/1ps
module ls_host_model (
   output logic scl,
   output logic sdaPull,
   input wire logic sdaLine
);
   localparam int Q_NS = 700; // quarter bit; keeps scl low above 8 link cycles
   int nacks; // bytes the target left unacknowledged

   initial begin
      scl = 1'b1;
      sdaPull = 1'b0;
      nacks = 0;
   end

   // start or repeated start: data falls while clock high
   task automatic start();
      sdaPull = 1'b0;
      #Q_NS scl = 1'b1;
      #Q_NS sdaPull = 1'b1;
      #Q_NS scl = 1'b0;
      #Q_NS;
   endtask

   // stop: data rises while clock high
   task automatic stop();
      sdaPull = 1'b1;
      #Q_NS scl = 1'b1;
      #Q_NS sdaPull = 1'b0;
      #Q_NS;
   endtask

   // one clock: drive b (1 = release), sample the wire while high
   task automatic xfer(input logic b, output logic r);
      sdaPull = ~b;
      #Q_NS scl = 1'b1;
      #Q_NS r = sdaLine;
      #Q_NS scl = 1'b0;
      #Q_NS;
   endtask

   task automatic putByte(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) xfer(d[i], r);
      xfer(1'b1, r);
      if (r !== 1'b0) nacks++;
   endtask

   task automatic getByte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
      xfer(last, r);
   endtask

   // word write: address, code, low byte, high byte
   task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
      start();
      putByte(8'h52);
      putByte(cmd);
      putByte(data[7:0]);
      putByte(data[15:8]);
      stop();
   endtask

   // word read through repeated start, last byte not acknowledged
   task automatic rd(input logic [7:0] cmd, output logic [15:0] data);
      start();
      putByte(8'h52);
      putByte(cmd);
      start();
      putByte(8'h53);
      getByte(1'b0, data[7:0]);
      getByte(1'b1, data[15:8]);
      stop();
   endtask
endmodule // ls_host_model

// file: verification/ls_light_sensor_regs_tb_top.sv
`timescale 1ns/1ps
`include "ls_defines.svh"
module ls_light_sensor_regs_tb_top
   import ls_pkg::*;
;
   typedef struct packed {
      logic [7:0] cmd;
      logic [15:0] wdata;
      logic [15:0] rexp;
   } ls_row_t;
   localparam logic [7:0] WR_ADDR = {`LS_TARGET_ADDR, 1'b0}; // address byte for writes
   logic clk = 1'b0; // core clock
   logic linkClk = 1'b0; // link clock, own phase
   logic reset_n = 1'b0;
   logic [15:0] lightRaw = 16'h0000;
   logic [15:0] bbandRaw = 16'h0000;
   logic hostScl, hostPull, sdaOut, sdaOe, intOut, intOe, b;
   logic afeActive, afeSensLow, afeGainDouble, afeBbandEn, measStrobe;
   int fail_count = 0;
   int tests_run = 0;
   wire sdaLine = ~(hostPull | sdaOe); // pulled-up data wire
   wire intLine = ~intOe; // pulled-up interrupt wire
   // writes to read-only places are ignored; reserved bits read zero
   ls_row_t rows [8] = '{
      '{`LS_CMD_UPPER, 16'hA55A, 16'hA55A}, '{`LS_CMD_LOWER, 16'h5AA5, 16'h5AA5},
      '{`LS_CMD_PSAVE, 16'hFFFF, 16'h0007}, '{`LS_CMD_PSAVE, 16'h0000, 16'h0000},
      '{`LS_CMD_CONFIG, 16'hE300, 16'h0300}, '{`LS_CMD_LIGHT, 16'hFFFF, 16'h0000},
      '{`LS_CMD_FLAGS, 16'hFFFF, 16'h0000}, '{8'h07, 16'hFFFF, 16'h0000}};

   always #50 clk = ~clk;
   always #80 linkClk = ~linkClk;

   // timeout must outlast the longest run of data held low in a legal transfer
   ls_light_sensor_regs #(.CYC_PER_MS(10), .TIMEOUT_CYC(600)) ls_light_sensor_regs_inst (
      .clk(clk), .reset_n(reset_n), .linkClk(linkClk), .sclIn(hostScl), .sdaIn(sdaLine),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .intIn(intLine), .intOut(intOut), .intOe(intOe),
      .lightRaw(lightRaw), .bbandRaw(bbandRaw), .afeActive(afeActive),
      .afeSensLow(afeSensLow), .afeGainDouble(afeGainDouble), .afeBbandEn(afeBbandEn),
      .measStrobe(measStrobe));
   ls_host_model ls_host_model_inst (.scl(hostScl), .sdaPull(hostPull), .sdaLine(sdaLine));

   // -----------------------------
   // helpers
   // -----------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [7:0] cmd, input logic [15:0] exp);
      logic [15:0] v;
      ls_host_model_inst.rd(cmd, v);
      check(v, exp);
   endtask
   task automatic w(input logic [7:0] cmd, input logic [15:0] data);
      ls_host_model_inst.wr(cmd, data);
   endtask
   task automatic setRaw(input logic [15:0] l, input logic [15:0] bb);
      @(posedge clk);
      #1 lightRaw = l;
      bbandRaw = bb;
   endtask
   // wait for n strobes; each samples the raw words applied before it
   task automatic waitMeas(input int n);
      int k;
      repeat (n) begin
         k = 0;
         do begin
            @(posedge clk);
            #1 k++;
         end while (measStrobe !== 1'b1 && k < 3000);
         if (measStrobe !== 1'b1) fail_count++;
      end
      repeat (20) @(posedge clk);
      #1;
   endtask
   task automatic endTest(input string name);
      $display("test %s done", name);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // watchdog well above the expected run of about 5 ms
   initial begin
      #8_000_000;
      fail_count++;
      finish_test();
   end

   // -----------------------------
   // main sequence
   // -----------------------------
   initial begin
      repeat (12) @(posedge clk);
      #1 reset_n = 1'b1;
      #1000;
      check({14'h0, afeActive, intOe}, 16'h0002);
      rc(`LS_CMD_CONFIG, `LS_CONFIG_RESET);
      rc(`LS_CMD_UPPER, `LS_UPPER_RESET);
      rc(`LS_CMD_LOWER, `LS_THRESH_RESET);
      endTest("reset");
      foreach (rows[i]) begin
         w(rows[i].cmd, rows[i].wdata);
         rc(rows[i].cmd, rows[i].rexp);
      end
      endTest("register rows");
      setRaw(16'h1234, 16'h9000);
      w(`LS_CMD_CONFIG, 16'h1F04);
      waitMeas(2);
      check({13'h0, afeSensLow, afeGainDouble, afeBbandEn}, 16'h0007);
      rc(`LS_CMD_LIGHT, 16'h2468);
      rc(`LS_CMD_BBAND, 16'hFFFF);
      w(`LS_CMD_CONFIG, 16'h0300);
      setRaw(16'h1234, 16'h0111);
      waitMeas(2);
      rc(`LS_CMD_LIGHT, 16'h1234);
      rc(`LS_CMD_BBAND, 16'hFFFF);
      endTest("measure");
      // shutdown keeps the old word until woken
      w(`LS_CMD_CONFIG, 16'h0301);
      setRaw(16'h0ABC, 16'h0ABC);
      repeat (600) @(posedge clk);
      check({15'h0, afeActive}, 16'h0000);
      rc(`LS_CMD_LIGHT, 16'h1234);
      w(`LS_CMD_CONFIG, 16'h0300);
      waitMeas(1);
      rc(`LS_CMD_LIGHT, 16'h0ABC);
      endTest("shutdown");
      // window 0100..1000, persistence of two readings
      w(`LS_CMD_UPPER, 16'h1000);
      w(`LS_CMD_LOWER, 16'h0100);
      w(`LS_CMD_CONFIG, 16'h0312);
      setRaw(16'h2000, 16'h0ABC);
      waitMeas(1);
      check({15'h0, intLine}, 16'h0001);
      waitMeas(1);
      check({15'h0, intLine}, 16'h0000);
      setRaw(16'h0ABC, 16'h0ABC);
      rc(`LS_CMD_FLAGS, 16'h4000);
      check({15'h0, intLine}, 16'h0001);
      w(`LS_CMD_CONFIG, 16'h0310);
      setRaw(16'h0050, 16'h0ABC);
      waitMeas(3);
      check({15'h0, intLine}, 16'h0001);
      rc(`LS_CMD_FLAGS, 16'h0000);
      setRaw(16'h0ABC, 16'h0ABC);
      waitMeas(1);
      w(`LS_CMD_CONFIG, 16'h031E);
      setRaw(16'h0ABC, 16'h0050);
      waitMeas(2);
      check({15'h0, intLine}, 16'h0000);
      setRaw(16'h0ABC, 16'h0ABC);
      rc(`LS_CMD_FLAGS, 16'h8000);
      endTest("interrupt");
      // foreign address gets no answer
      ls_host_model_inst.start();
      ls_host_model_inst.putByte(8'h54);
      ls_host_model_inst.stop();
      check(16'(ls_host_model_inst.nacks), 16'h0001);
      // clock held low during the acknowledge until the bus gives up
      ls_host_model_inst.start();
      for (int i = 7; i >= 0; i--) ls_host_model_inst.xfer(WR_ADDR[i], b);
      #3000 check({15'h0, sdaOe}, 16'h0001);
      #80000 check({15'h0, sdaOe}, 16'h0001);
      #20000 check({15'h0, sdaOe}, 16'h0000);
      ls_host_model_inst.stop();
      rc(`LS_CMD_UPPER, 16'h1000);
      endTest("bus faults");
      finish_test();
   end
endmodule // ls_light_sensor_regs_tb_top
